/* hw/sbp_protect.sv */
// sbp_protect: per-block persistent/dynamic protection with guard lock
// assumes an apb master on pclk; pwd_mode_pin is a board strap
//
// Operation
// - 128 blocks of 256KB, one bit each kind
// - persistent bits kept across power loss
// - program bits singly to 0, erase all
// - program and erase take timed waits
// - status shows busy during program/erase
// - erase preprograms and verifies internally
// - no array reads while programming
// - erase is global, no block address
// - factory state reads all ones
// - dynamic bits volatile, freely written
// - dynamic bit matters only if persistent is 1
// - one lock bit guards persistent bits
// - locked program/erase rejected and flagged failed
// - persistent mode: reset sets lock, sticky clear
// - password mode: reset clears, unlock sets
// - persistent bit read within access latency
// - soft reset keeps the lock bit
// - all resets unprotect dynamic bits
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module sbp_protect
    import sbp_pkg::*;
#(
    parameter int PROG_CYCLES  = sbp_pkg::PROG_CYC_DEF,
    parameter int ERASE_CYCLES = sbp_pkg::ERASE_CYC_DEF
) (
    // clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // apb slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [sbp_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // strap: 1 selects password mode
    input  wire logic                     pwd_mode_pin,
    // array side
    input  wire logic [sbp_pkg::BLK_W-1:0] chk_blk,
    output logic                          chk_protected,
    output logic                          array_read_ok,
    output logic                          busy
);
    import sbp_pkg::*;

    typedef struct packed {
        sbp_st_e           st;
        logic [31:0]       cnt;
        logic [BLK_W-1:0]  blk;
        logic [BLK_W-1:0]  idx;
        logic [NBLK-1:0]   dynamic_protect_bit;
        logic              lock;
        logic              mode;
        logic              mode_ok;
        logic [1:0]        warm;
        logic [2:0]        sync;
        logic              fail;
        logic [ADDR_W-1:0] qry;
        logic [BLK_W-1:0]  chk_blk;
        logic              chk_dyb;
        logic [31:0]       prdata;
    } sbp_s;

    localparam sbp_s RST_S = '{st: S_IDLE, cnt: 32'h0, blk: '0, idx: '0,
                               dynamic_protect_bit: '1, lock: LOCK_RST, mode: 1'b0,
                               mode_ok: 1'b0, warm: 2'h0, sync: 3'h0,
                               fail: FAIL_RST, qry: '0, chk_blk: '0,
                               chk_dyb: 1'b1, prdata: 32'h0};

    sbp_s s;
    sbp_s next_s;

    sbp_mem_if #(.N(NBLK), .AW(BLK_W)) m ();

    if (PROG_CYCLES < 1 || ERASE_CYCLES < 1 || NBLK != (1 << BLK_W)) begin : g_bad
        $error("sbp_protect: unusable timing or block count");
    end

    function automatic logic reg_hit(input logic [APB_AW-1:0] a);
        reg_hit = (a == OFF_CMD) || (a == OFF_STAT) || (a == OFF_QRY) || (a == OFF_RES);
    endfunction : reg_hit

    function automatic logic [BLK_W-1:0] qry_blk(input logic [ADDR_W-1:0] a);
        qry_blk = a[ADDR_W-1:BLK_LSB];
    endfunction : qry_blk

    logic             wr_cmd;
    sbp_op_e          op;
    logic [BLK_W-1:0] op_blk;
    logic             op_val;

    assign wr_cmd = psel && penable && pwrite && (paddr == OFF_CMD);
    assign op     = sbp_op_e'(pwdata[CMD_OP_LSB +: 3]);
    assign op_blk = pwdata[CMD_BLK_LSB +: BLK_W];
    assign op_val = pwdata[CMD_VAL_BIT];

    always_comb begin
        next_s      = s;
        m.we        = 1'b0;
        m.waddr     = s.blk;
        m.wdata     = 1'b0;
        m.all_set   = 1'b0;
        m.all_clr   = 1'b0;
        m.raddr     = qry_blk(s.qry);
        m.caddr     = chk_blk;

        // strap: three stages, counted once the last two agree
        next_s.sync = {s.sync[1:0], pwd_mode_pin};
        if (s.warm != 2'(STRAP_WARM)) begin
            next_s.warm = s.warm + 2'h1;
        end else if (!s.mode_ok && (s.sync[1] == s.sync[2])) begin
            next_s.mode_ok = 1'b1;
            next_s.mode    = s.sync[2];
            next_s.lock    = !s.sync[2];
        end

        next_s.chk_blk = chk_blk;
        next_s.chk_dyb = s.dynamic_protect_bit[chk_blk];

        // apb read data is captured in the setup cycle
        if (psel && !penable) begin
            next_s.prdata = 32'h0;
            case (paddr)
                OFF_STAT: begin
                    next_s.prdata[ST_BUSY] = (s.st != S_IDLE);
                    next_s.prdata[ST_FAIL] = s.fail;
                    next_s.prdata[ST_LOCK] = s.lock;
                    next_s.prdata[ST_MODE] = s.mode;
                end
                OFF_QRY: next_s.prdata[ADDR_W-1:0] = s.qry;
                OFF_RES: begin
                    next_s.prdata[RES_PPB]  = m.rdata;
                    next_s.prdata[RES_DYB]  = s.dynamic_protect_bit[qry_blk(s.qry)];
                    next_s.prdata[RES_PROT] = !(m.rdata && s.dynamic_protect_bit[qry_blk(s.qry)]);
                end
                default: next_s.prdata = 32'h0;
            endcase
        end
        if (psel && penable && pwrite && (paddr == OFF_QRY)) begin
            next_s.qry = pwdata[ADDR_W-1:0];
        end

        // commands
        if (wr_cmd) begin
            case (op)
                OP_DYB_WRITE: next_s.dynamic_protect_bit[op_blk] = op_val;
                OP_SOFT_RST:  next_s.dynamic_protect_bit = '1;
                OP_LOCK_CLR: begin
                    if (s.mode_ok) begin
                        next_s.lock = 1'b0;
                    end
                end
                OP_PWD_OK: begin
                    if (s.mode) begin
                        next_s.lock = 1'b1;
                    end
                end
                OP_PPB_PROG: begin
                    if (s.st == S_IDLE) begin
                        if (!s.lock) begin
                            next_s.fail = 1'b1;
                        end else begin
                            next_s.fail = 1'b0;
                            next_s.st   = S_PROG;
                            next_s.cnt  = 32'h0;
                            next_s.blk  = op_blk;
                        end
                    end
                end
                OP_PPB_ERASE: begin
                    if (s.st == S_IDLE) begin
                        if (!s.lock) begin
                            next_s.fail = 1'b1;
                        end else begin
                            next_s.fail = 1'b0;
                            next_s.st   = S_PRE;
                        end
                    end
                end
                default: ;
            endcase
        end

        // program / erase sequencer
        case (s.st)
            S_IDLE: ;
            S_PROG: begin
                next_s.cnt = s.cnt + 32'h1;
                if (s.cnt == 32'(PROG_CYCLES - 1)) begin
                    m.we      = 1'b1;
                    m.wdata   = 1'b0;
                    next_s.st = S_IDLE;
                end
            end
            S_PRE: begin
                m.all_clr  = 1'b1;
                next_s.idx = '0;
                next_s.st  = S_VER;
            end
            S_VER: begin
                m.raddr   = s.idx;
                next_s.st = S_VCHK;
            end
            S_VCHK: begin
                if (m.rdata) begin
                    next_s.fail = 1'b1;
                    next_s.st   = S_IDLE;
                end else if (s.idx == BLK_W'(NBLK - 1)) begin
                    next_s.cnt = 32'h0;
                    next_s.st  = S_ERASE;
                end else begin
                    next_s.idx = s.idx + BLK_W'(1);
                    next_s.st  = S_VER;
                end
            end
            S_ERASE: begin
                next_s.cnt = s.cnt + 32'h1;
                if (s.cnt == 32'(ERASE_CYCLES - 1)) begin
                    m.all_set = 1'b1;
                    next_s.st = S_IDLE;
                end
            end
            default: next_s.st = S_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= RST_S;
        end else begin
            s <= next_s;
        end
    end

    sbp_nv_store #(.N(NBLK), .AW(BLK_W)) u_store (
        .pclk    (pclk),
        .presetn (presetn),
        .m       (m)
    );

    assign prdata        = s.prdata;
    assign pready        = 1'b1;
    assign pslverr       = psel && penable && !reg_hit(paddr);
    assign busy          = (s.st != S_IDLE);
    assign array_read_ok = (s.st != S_PROG);
    assign chk_protected = !(m.cdata && s.chk_dyb);

    a_locked_reject: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_cmd && (op == OP_PPB_PROG || op == OP_PPB_ERASE) && !s.lock
            && s.st == S_IDLE) |=> (s.fail && s.st == S_IDLE))
        else $error("locked persistent command was not rejected");
    a_lock_no_resume: assert property (@(posedge pclk) disable iff (!presetn)
        (s.mode_ok && !s.mode && !s.lock) |=> !s.lock)
        else $error("lock set again in persistent mode");
    a_pwd_unlock: assert property (@(posedge pclk) disable iff (!presetn)
        (s.mode_ok && s.mode && !s.lock && !(wr_cmd && op == OP_PWD_OK)) |=> !s.lock)
        else $error("lock set without password unlock");
    a_soft_lock_kept: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_cmd && op == OP_SOFT_RST && s.mode_ok) |=> $stable(s.lock))
        else $error("soft reset changed the lock");
    a_soft_dyb_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_cmd && op == OP_SOFT_RST) |=> (&s.dynamic_protect_bit))
        else $error("soft reset left a dynamic bit protected");
    a_dyb_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_cmd && op == OP_DYB_WRITE) |=> (s.dynamic_protect_bit[$past(op_blk)] == $past(op_val)))
        else $error("dynamic bit write lost");
    a_prog_busy_time: assert property (@(posedge pclk) disable iff (!presetn)
        (s.st == S_PROG) |-> (s.cnt < 32'(PROG_CYCLES)) && busy && !array_read_ok)
        else $error("program window wrong");
    a_prog_start: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_cmd && op == OP_PPB_PROG && s.lock && s.st == S_IDLE)
            |=> (busy && !array_read_ok) [*2])
        else $error("program did not report busy");
    a_erase_preprog: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_cmd && op == OP_PPB_ERASE && s.lock && s.st == S_IDLE)
            |=> m.all_clr ##1 (s.st == S_VER))
        else $error("erase skipped preprogramming");
    a_dyb_protects: assert property (@(posedge pclk) disable iff (!presetn)
        (!s.dynamic_protect_bit[chk_blk] && !(wr_cmd && (op == OP_SOFT_RST || op == OP_DYB_WRITE)))
            |=> chk_protected)
        else $error("cleared dynamic bit did not protect");
    a_read_ready: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable) |-> pready)
        else $error("apb access not answered");
    a_chk_dyb_track: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(wr_cmd) |-> (s.chk_dyb == s.dynamic_protect_bit[s.chk_blk]))
        else $error("dynamic bit seen by array check is stale");
    a_erase_time: assert property (@(posedge pclk) disable iff (!presetn)
        (s.st == S_ERASE) |-> (s.cnt < 32'(ERASE_CYCLES)) && busy && array_read_ok)
        else $error("erase window wrong");
    a_strap_lock: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(s.mode_ok) |-> (s.lock == !s.mode))
        else $error("reset lock value does not match mode");
    a_lock_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_cmd && op == OP_LOCK_CLR && s.mode_ok) |=> !s.lock)
        else $error("lock clear command ignored");
endmodule : sbp_protect

/* common/sbp_pkg.sv */
// sbp_pkg: constants of the block protection logic
// assumes a 50 MHz pclk and 32-bit APB access
package sbp_pkg;
    // array layout: 256KB blocks of 4KB sectors
    localparam int NBLK         = 128;
    localparam int BLK_W        = 7;
    localparam int ADDR_W       = 25;
    localparam int BLK_LSB      = 18;
    localparam int SECT_KB      = 4;
    localparam int SECT_PER_BLK = 64;

    // apb register offsets
    localparam int         APB_AW   = 8;
    localparam logic [7:0] OFF_CMD  = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_QRY  = 8'h08;
    localparam logic [7:0] OFF_RES  = 8'h0C;

    // command register fields
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_BLK_LSB = 8;
    localparam int CMD_VAL_BIT = 16;

    // status and result bits
    localparam int ST_BUSY  = 0;
    localparam int ST_FAIL  = 1;
    localparam int ST_LOCK  = 2;
    localparam int ST_MODE  = 3;
    localparam int RES_PPB  = 0;
    localparam int RES_DYB  = 1;
    localparam int RES_PROT = 2;

    // reset values
    localparam logic LOCK_RST = 1'b0;
    localparam logic FAIL_RST = 1'b0;

    // timing
    localparam int CLK_MHZ       = 50;
    localparam int PROG_TIME_US  = 200;
    localparam int ERASE_TIME_US = 50000;
    localparam int PROG_CYC_DEF  = PROG_TIME_US * CLK_MHZ;
    localparam int ERASE_CYC_DEF = ERASE_TIME_US * CLK_MHZ;
    localparam int STRAP_WARM    = 3;

    typedef enum logic [2:0] {
        OP_NONE      = 3'h0,
        OP_PPB_PROG  = 3'h1,
        OP_PPB_ERASE = 3'h2,
        OP_DYB_WRITE = 3'h3,
        OP_LOCK_CLR  = 3'h4,
        OP_PWD_OK    = 3'h5,
        OP_SOFT_RST  = 3'h6
    } sbp_op_e;

    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_PROG  = 3'h1,
        S_PRE   = 3'h2,
        S_VER   = 3'h3,
        S_VCHK  = 3'h4,
        S_ERASE = 3'h5
    } sbp_st_e;
endpackage : sbp_pkg

/* common/sbp_mem_if.sv */
// sbp_mem_if: port of the non-volatile protection bit store
// assumes controller and store share pclk
`timescale 1ns/1ps
interface sbp_mem_if #(parameter int N = 128, parameter int AW = 7);
    logic          we;
    logic [AW-1:0] waddr;
    logic          wdata;
    logic          all_set;
    logic          all_clr;
    logic [AW-1:0] raddr;
    logic          rdata;
    logic [AW-1:0] caddr;
    logic          cdata;

    modport ctrl (output we, waddr, wdata, all_set, all_clr, raddr, caddr,
                  input rdata, cdata);
    modport mem  (input we, waddr, wdata, all_set, all_clr, raddr, caddr,
                  output rdata, cdata);
endinterface : sbp_mem_if

/* hw/sbp_nv_store.sv */
// sbp_nv_store: persistent protection bits, kept without reset
// assumes the controller never writes and erases in one cycle
`timescale 1ns/1ps
module sbp_nv_store #(
    parameter int N  = 128,
    parameter int AW = 7
) (
    // clock, reset used only to quiet checks
    input  wire logic pclk,
    input  wire logic presetn,
    // store port
    sbp_mem_if.mem    m
);
    import sbp_pkg::*;

    typedef struct packed {
        logic [N-1:0] bits;
        logic         rdata;
        logic         cdata;
    } sbp_nv_s;

    // factory state: all erased
    sbp_nv_s s = '{bits: '1, rdata: 1'b1, cdata: 1'b1};
    sbp_nv_s next_s;

    if (N > (1 << AW)) begin : g_bad_n
        $error("sbp_nv_store: N does not fit address width");
    end

    always_comb begin
        next_s = s;
        if (m.all_clr) begin
            next_s.bits = '0;
        end else if (m.all_set) begin
            next_s.bits = '1;
        end else if (m.we) begin
            next_s.bits[m.waddr] = m.wdata;
        end
        next_s.rdata = s.bits[m.raddr];
        next_s.cdata = s.bits[m.caddr];
    end

    // no reset: contents survive resets
    always_ff @(posedge pclk) begin
        s <= next_s;
    end

    assign m.rdata = s.rdata;
    assign m.cdata = s.cdata;

    a_erase_all_ones: assert property (@(posedge pclk) disable iff (!presetn)
        (m.all_set && !m.all_clr) |=> (&s.bits))
        else $error("bulk erase left a bit at zero");
    a_prog_one_bit: assert property (@(posedge pclk) disable iff (!presetn)
        (m.we && !m.all_set && !m.all_clr)
            |=> (s.bits[$past(m.waddr)] == $past(m.wdata)))
        else $error("single bit program not stored");
endmodule : sbp_nv_store

/* tb/sbp_host_model.sv */
// sbp_host_model: apb host issuing protection commands
// assumes pclk shared with the device; pready sampled at rising edge
`timescale 1ns/1ps
module sbp_host_model (
    // clock
    input  wire logic        pclk,
    // apb master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    import sbp_pkg::*;

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // one apb transfer, request held until pready seen high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    // query one block: base address, unused bits zero
    task automatic query(input logic [6:0] blk, output logic [31:0] r);
        logic e;
        xfer(1'b1, OFF_QRY, {7'h00, blk, 18'h00000}, r, e);
        repeat (2) @(posedge pclk);
        xfer(1'b0, OFF_RES, 32'h0000_0000, r, e);
    endtask : query
endmodule : sbp_host_model

/* tb/testbench.sv */
// testbench: random and corner tests of the block protection logic
// assumes sbp_protect with shortened program and erase times
`timescale 1ns/1ps
module testbench;
    import sbp_pkg::*;
    localparam int PROG_N  = 20;
    localparam int ERASE_N = 40;

    logic        pclk, presetn, pwd_mode_pin, psel, penable, pwrite;
    logic        pready, pslverr, chk_protected, array_read_ok, busy, e, v;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [6:0]  chk_blk, b, pb, ob;
    int          fail_count, tests_run, cyc, seed, busy_cyc;

    sbp_protect #(.PROG_CYCLES(PROG_N), .ERASE_CYCLES(ERASE_N)) u_sbp_protect (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pwd_mode_pin(pwd_mode_pin),
        .chk_blk(chk_blk), .chk_protected(chk_protected),
        .array_read_ok(array_read_ok), .busy(busy));

    sbp_host_model u_sbp_host_model (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    initial pclk = 1'b0;
    always #10 pclk = ~pclk;

    always @(negedge pclk) if (busy === 1'b1) busy_cyc++;

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : chk

    function automatic logic [31:0] exp_res(input logic p, input logic d);
        return {29'h0, ~(p & d), d, p};
    endfunction : exp_res

    function automatic logic [31:0] exp_st(input logic bz, fl, lk, md);
        return {28'h0, md, lk, fl, bz};
    endfunction : exp_st

    task automatic cmd(input logic [2:0] op, input logic [6:0] blk, input logic val);
        u_sbp_host_model.xfer(1'b1, OFF_CMD, {15'h0, val, 1'b0, blk, 5'h0, op}, r, e);
    endtask : cmd

    task automatic stat();
        u_sbp_host_model.xfer(1'b0, OFF_STAT, 32'h0, r, e);
        r = r & 32'h0000_000F;
    endtask : stat

    task automatic res(input logic [6:0] blk);
        u_sbp_host_model.query(blk, r);
        r = r & 32'h0000_0007;
    endtask : res

    task automatic wait_idle();
        do stat(); while (r[ST_BUSY] !== 1'b0);
    endtask : wait_idle

    task automatic hw_reset(input logic pm);
        @(posedge pclk);
        presetn      <= 1'b0;
        pwd_mode_pin <= pm;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
    endtask : hw_reset

    initial begin
        presetn = 1'b0;
        pwd_mode_pin = 1'b0;
        chk_blk = 7'h00;
        seed = 62883;
        fail_count = 0;
        tests_run = 0;
        cyc = 0;
        busy_cyc = 0;
        hw_reset(1'b0);
        stat();
        chk(r, exp_st(1'b0, 1'b0, 1'b1, 1'b0));
        b = 7'h7F;
        res(b);
        chk(r, exp_res(1'b1, 1'b1));
        $display("test reset_state done");
        for (int i = 0; i < 8; i++) begin
            b = (i == 0) ? 7'h00 : 7'($random(seed));
            v = 1'($random(seed));
            cmd(3'h3, b, v);
            res(b);
            chk(r, exp_res(1'b1, v));
            chk_blk <= b;
            repeat (2) @(negedge pclk);
            chk(chk_protected, !v);
        end
        $display("test dynamic_bits done");
        pb = 7'($random(seed));
        ob = pb + 7'h01;
        cmd(3'h3, pb, 1'b1);
        cmd(3'h3, ob, 1'b1);
        busy_cyc = 0;
        cmd(3'h1, pb, 1'b0);
        @(negedge pclk);
        chk(array_read_ok, 1'b0);
        stat();
        chk(r, exp_st(1'b1, 1'b0, 1'b1, 1'b0));
        wait_idle();
        chk(busy_cyc, PROG_N);
        chk(array_read_ok, 1'b1);
        res(pb);
        chk(r, exp_res(1'b0, 1'b1));
        res(ob);
        chk(r, exp_res(1'b1, 1'b1));
        $display("test persist_program done");
        cmd(3'h3, ob, 1'b0);
        cmd(3'h6, 7'h00, 1'b0);
        res(ob);
        chk(r, exp_res(1'b1, 1'b1));
        stat();
        chk(r, exp_st(1'b0, 1'b0, 1'b1, 1'b0));
        $display("test soft_reset done");
        cmd(3'h4, 7'h00, 1'b0);
        stat();
        chk(r, exp_st(1'b0, 1'b0, 1'b0, 1'b0));
        cmd(3'h5, 7'h00, 1'b0);
        stat();
        chk(r, exp_st(1'b0, 1'b0, 1'b0, 1'b0));
        cmd(3'h1, ob, 1'b0);
        stat();
        chk(r, exp_st(1'b0, 1'b1, 1'b0, 1'b0));
        cmd(3'h2, 7'h00, 1'b0);
        stat();
        chk(r, exp_st(1'b0, 1'b1, 1'b0, 1'b0));
        res(ob);
        chk(r, exp_res(1'b1, 1'b1));
        res(pb);
        chk(r, exp_res(1'b0, 1'b1));
        $display("test lock_refusal done");
        hw_reset(1'b1);
        stat();
        chk(r, exp_st(1'b0, 1'b0, 1'b0, 1'b1));
        res(pb);
        chk(r, exp_res(1'b0, 1'b1));
        cmd(3'h5, 7'h00, 1'b0);
        stat();
        chk(r, exp_st(1'b0, 1'b0, 1'b1, 1'b1));
        cmd(3'h2, 7'h00, 1'b0);
        stat();
        chk(r, exp_st(1'b1, 1'b0, 1'b1, 1'b1));
        wait_idle();
        res(pb);
        chk(r, exp_res(1'b1, 1'b1));
        hw_reset(1'b0);
        stat();
        chk(r, exp_st(1'b0, 1'b0, 1'b1, 1'b0));
        $display("test password_erase done");
        u_sbp_host_model.xfer(1'b0, 8'h10, 32'h0, r, e);
        chk(e, 1'b1);
        u_sbp_host_model.xfer(1'b0, OFF_CMD, 32'h0, r, e);
        chk(r, 32'h0);
        chk(e, 1'b0);
        $display("test apb_map done");
        end_sim();
    end
endmodule : testbench
